// [common/pisr_regs.svh]
/*
 * Named codes and timing figures of the package idle state resolver.
 * Assumes inclusion by bare name from the common folder.
 */
`ifndef PISR_REGS_SVH
`define PISR_REGS_SVH

// ****************************************************************
// Core idle state codes, numerically ordered by depth
// ****************************************************************
`define PISR_CC0 3'h0
`define PISR_CC1 3'h1
`define PISR_CC3 3'h3
`define PISR_CC6 3'h6
`define PISR_CC7 3'h7

// ****************************************************************
// Sizes
// ****************************************************************
`define PISR_NCORES 4
`define PISR_CIDX_W 2

// ****************************************************************
// Timing
// ****************************************************************
`define PISR_CLK_MHZ 100
// Settle time between clock step and voltage step
`define PISR_RAMP_NS 100

`endif

// [common/pisr_pkg.sv]
/*
 * Types shared by the package idle state resolver modules.
 * Assumes nothing of its surroundings.
 */
package pisr_pkg;

	// Codes rise with depth so depth compares numerically
	typedef enum logic [2:0]
	{
		PKG_C0 = 3'b000,
		PKG_C1 = 3'b001,
		PKG_ENHANCED_IDLE = 3'b010,
		PKG_C2 = 3'b011,
		PKG_C3 = 3'b100,
		PKG_C6 = 3'b101,
		PKG_C7 = 3'b110
	} pisr_pstate_t;

	typedef enum logic [2:0]
	{
		SEQ_RUN = 3'b000,
		SEQ_ACTIVE = 3'b001,
		SEQ_REENTER = 3'b010,
		SEQ_MEM = 3'b011,
		SEQ_HOLD = 3'b100
	} pisr_seq_t;

	typedef enum logic [1:0]
	{
		RAMP_HIGH = 2'b00,
		RAMP_CLK_LOW = 2'b01,
		RAMP_VOLT_LOW = 2'b10,
		RAMP_VOLT_UP = 2'b11
	} pisr_ramp_t;

endpackage

// [hdl/pisr_core_merge.sv]
/*
 * Merges two idle state requests into the shallower one.
 * Assumes both inputs use the numerically ordered core codes.
 */
`timescale 1ns/1ps
`include "pisr_regs.svh"

module pisr_core_merge
(
	input logic [2:0] a_state,
	input logic a_hint,
	input logic [2:0] b_state,
	input logic b_hint,
	output logic [2:0] m_state,
	output logic m_hint
);

	// Smallest number wins; C7 survives only if both sides are C7
	assign m_state = (a_state < b_state) ? a_state : b_state;
	assign m_hint = a_hint & b_hint;

endmodule // pisr_core_merge

// [hdl/pisr_c1e_ramp.sv]
/*
 * Enhanced C1 power sequencer: clock down, then voltage down.
 * Assumes the request level comes from a flip-flop on the same clock.
 */
`timescale 1ns/1ps
`include "pisr_regs.svh"

module pisr_enhanced_idle_ramp
(
	input logic clk,
	input logic resetn,
	input logic enter,
	output logic clk_min_r,
	output logic volt_low_r
);
	import pisr_pkg::*;

	localparam int SETTLE = (`PISR_RAMP_NS * `PISR_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SETTLE_C = 8'(SETTLE < 1 ? 1 : SETTLE);

	typedef struct packed
	{
		pisr_ramp_t ph;
		logic [7:0] cnt;
		logic clk_min;
		logic volt_low;
	} pisr_ramp_st_t;

	pisr_ramp_st_t st_r;
	pisr_ramp_st_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (st_r.cnt != 8'h00)
			st_nxt.cnt = st_r.cnt - 8'h01;
		case (st_r.ph)
			RAMP_HIGH:
				if (enter)
				begin
					st_nxt.clk_min = 1'b1;
					st_nxt.cnt = SETTLE_C;
					st_nxt.ph = RAMP_CLK_LOW;
				end
			RAMP_CLK_LOW:
				if (!enter)
				begin
					st_nxt.clk_min = 1'b0;
					st_nxt.ph = RAMP_HIGH;
				end
				else if (st_r.cnt == 8'h00)
				begin
					st_nxt.volt_low = 1'b1;
					st_nxt.ph = RAMP_VOLT_LOW;
				end
			RAMP_VOLT_LOW:
				if (!enter)
				begin
					// Voltage must be back before the clock speeds up
					st_nxt.volt_low = 1'b0;
					st_nxt.cnt = SETTLE_C;
					st_nxt.ph = RAMP_VOLT_UP;
				end
			default:
				if (st_r.cnt == 8'h00)
				begin
					st_nxt.clk_min = 1'b0;
					st_nxt.ph = RAMP_HIGH;
				end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign clk_min_r = st_r.clk_min;
	assign volt_low_r = st_r.volt_low;

endmodule // pisr_enhanced_idle_ramp

// [hdl/pisr_top.sv]
/*
 * Package idle state resolver: merges core requests, applies platform
 * permission and limits, and handles wake and memory break events.
 * Assumes all inputs are synchronous to clk; the platform holds its
 * permission inputs stable until plat_ack pulses.
 */
`timescale 1ns/1ps
`include "pisr_regs.svh"

module pisr_top
(
	input logic clk,
	input logic resetn,
	input logic [2:0] core0_state,
	input logic [2:0] core1_state,
	input logic [2:0] core2_state,
	input logic [2:0] core3_state,
	input logic [`PISR_NCORES-1:0] core_enhanced_idle_hint,
	input logic gfx_deep,
	input logic enh_idle_enable,
	input logic auto_promote_enable,
	input logic pkg_limit_c1,
	input logic latency_limit_c2,
	input logic discrete_gfx,
	input logic c7_efficient,
	input pisr_pkg::pisr_pstate_t plat_allow,
	input logic plat_hold,
	input pisr_pkg::pisr_pstate_t plat_hold_state,
	input logic mem_req,
	input logic mem_outstanding,
	input logic wake_valid,
	input logic [`PISR_CIDX_W-1:0] wake_core,
	input logic wake_masked,
	output pisr_pkg::pisr_pstate_t pkg_state_r,
	output logic [`PISR_NCORES-1:0] core_power_up_r,
	output logic wake_fwd_r,
	output logic [`PISR_CIDX_W-1:0] wake_fwd_core_r,
	output logic plat_ack_r,
	output logic llc_flush_allow_r,
	output logic sa_power_off_r,
	output logic core_clk_min_r,
	output logic core_volt_low_r
);
	import pisr_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed
	{
		pisr_pstate_t pkg;
		pisr_pstate_t prev;
		pisr_seq_t seq;
		logic [`PISR_CIDX_W-1:0] woken;
		logic [`PISR_NCORES-1:0] power_up;
		logic wake_fwd;
		logic plat_ack;
		pisr_pstate_t allow_q;
		logic hold_q;
		pisr_pstate_t hold_state_q;
		logic llc_flush;
		logic sa_off;
	} pisr_st_t;

	pisr_st_t st_r;
	pisr_st_t st_nxt;

	// ****************************************************************
	// Core request merge tree
	// ****************************************************************
	logic [2:0] core_st [`PISR_NCORES];
	logic [2:0] m01_state;
	logic [2:0] m23_state;
	logic [2:0] min_state;
	logic m01_hint;
	logic m23_hint;
	logic all_hint;

	assign core_st[0] = core0_state;
	assign core_st[1] = core1_state;
	assign core_st[2] = core2_state;
	assign core_st[3] = core3_state;

	pisr_core_merge u_m01
	(
		.a_state(core0_state),
		.a_hint(core_enhanced_idle_hint[0]),
		.b_state(core1_state),
		.b_hint(core_enhanced_idle_hint[1]),
		.m_state(m01_state),
		.m_hint(m01_hint)
	);

	pisr_core_merge u_m23
	(
		.a_state(core2_state),
		.a_hint(core_enhanced_idle_hint[2]),
		.b_state(core3_state),
		.b_hint(core_enhanced_idle_hint[3]),
		.m_state(m23_state),
		.m_hint(m23_hint)
	);

	pisr_core_merge u_mall
	(
		.a_state(m01_state),
		.a_hint(m01_hint),
		.b_state(m23_state),
		.b_hint(m23_hint),
		.m_state(min_state),
		.m_hint(all_hint)
	);

	// ****************************************************************
	// Target package state
	// ****************************************************************
	pisr_pstate_t tgt;
	pisr_pstate_t c1_kind;
	logic is_deep;

	always_comb
	begin
		// Explicit hints, auto-promotion, or the C1 cap on deeper cores
		if (enh_idle_enable && (all_hint || auto_promote_enable ||
			min_state > `PISR_CC1))
			c1_kind = PKG_ENHANCED_IDLE;
		else
			c1_kind = PKG_C1;
		if (min_state == `PISR_CC0)
			tgt = PKG_C0;
		else if (min_state == `PISR_CC1 || pkg_limit_c1)
			tgt = c1_kind;
		else if (!gfx_deep)
			// Busy graphics keeps memory live; stop at the core level
			tgt = c1_kind;
		else if (latency_limit_c2)
			tgt = PKG_C2;
		else if (min_state == `PISR_CC3)
			tgt = PKG_C3;
		else if (min_state == `PISR_CC6)
			tgt = PKG_C6;
		else if (discrete_gfx || !c7_efficient)
			tgt = PKG_C6;
		else
			tgt = PKG_C7;
		// Permission caps depth; C0 allowed means none granted
		if (st_r.allow_q == PKG_C0)
			tgt = PKG_C0;
		else if (tgt > st_r.allow_q)
			tgt = st_r.allow_q;
	end

	assign is_deep = (st_r.pkg >= PKG_C3);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.power_up = '0;
		st_nxt.wake_fwd = 1'b0;
		// Permission is sampled once per change and acknowledged
		st_nxt.allow_q = plat_allow;
		st_nxt.hold_q = plat_hold;
		st_nxt.hold_state_q = plat_hold_state;
		st_nxt.plat_ack = (plat_allow != st_r.allow_q) ||
			(plat_hold != st_r.hold_q) ||
			(plat_hold_state != st_r.hold_state_q);
		case (st_r.seq)
			SEQ_RUN:
				if (wake_valid && st_r.pkg != PKG_C0)
				begin
					st_nxt.prev = st_r.pkg;
					st_nxt.power_up[wake_core] = 1'b1;
					st_nxt.wake_fwd = 1'b1;
					st_nxt.woken = wake_core;
					st_nxt.pkg = PKG_C0;
					if (wake_masked)
						st_nxt.seq = SEQ_REENTER;
					else
						st_nxt.seq = SEQ_ACTIVE;
				end
				else if (mem_req && is_deep)
				begin
					st_nxt.prev = st_r.pkg;
					if (st_r.hold_q)
					begin
						st_nxt.pkg = st_r.hold_state_q;
						st_nxt.seq = SEQ_HOLD;
					end
					else
					begin
						st_nxt.pkg = PKG_C2;
						st_nxt.seq = SEQ_MEM;
					end
				end
				else
					st_nxt.pkg = tgt;
			SEQ_ACTIVE:
				// Hold C0 until the woken core reports itself active
				if (core_st[st_r.woken] == `PISR_CC0)
					st_nxt.seq = SEQ_RUN;
			SEQ_REENTER:
			begin
				st_nxt.pkg = st_r.prev;
				st_nxt.seq = SEQ_RUN;
			end
			SEQ_MEM:
				if (st_r.hold_q)
				begin
					st_nxt.pkg = st_r.hold_state_q;
					st_nxt.seq = SEQ_HOLD;
				end
				else if (!mem_outstanding && !mem_req)
				begin
					st_nxt.pkg = st_r.prev;
					st_nxt.seq = SEQ_RUN;
				end
			default:
				if (!st_r.hold_q)
				begin
					st_nxt.pkg = st_r.prev;
					st_nxt.seq = SEQ_RUN;
				end
		endcase
		// Returns to an old state never outrun the live resolution:
		// an active core or a withdrawn grant wins
		if (st_nxt.pkg > tgt)
			st_nxt.pkg = tgt;
		// Cache kept while any core wants C6; only all-C7 may flush
		st_nxt.llc_flush = (st_nxt.pkg == PKG_C7) ||
			(st_nxt.pkg == PKG_C6 && min_state == `PISR_CC7);
		st_nxt.sa_off = (st_nxt.pkg == PKG_C7);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_r <= '0;
		end
		else
			st_r <= st_nxt;
	end

	// ****************************************************************
	// Enhanced C1 power sequencing
	// ****************************************************************
	pisr_enhanced_idle_ramp u_ramp
	(
		.clk(clk),
		.resetn(resetn),
		.enter(st_r.pkg == PKG_ENHANCED_IDLE),
		.clk_min_r(core_clk_min_r),
		.volt_low_r(core_volt_low_r)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign pkg_state_r = st_r.pkg;
	assign core_power_up_r = st_r.power_up;
	assign wake_fwd_r = st_r.wake_fwd;
	assign wake_fwd_core_r = st_r.woken;
	assign plat_ack_r = st_r.plat_ack;
	assign llc_flush_allow_r = st_r.llc_flush;
	assign sa_power_off_r = st_r.sa_off;

endmodule // pisr_top

// [tb/pisr_top_sva.sv]
/* Concurrent checks on the package idle state resolver ports.
 * Assumes it is bound to pisr_top and sees only its ports. */
`timescale 1ns/1ps
`include "pisr_regs.svh"
module pisr_top_sva
(
	input logic clk,
	input logic resetn,
	input logic [2:0] core0_state,
	input logic [2:0] core1_state,
	input logic [2:0] core2_state,
	input logic [2:0] core3_state,
	input logic gfx_deep,
	input logic pkg_limit_c1,
	input pisr_pkg::pisr_pstate_t plat_allow,
	input logic plat_hold,
	input logic mem_req,
	input logic wake_valid,
	input pisr_pkg::pisr_pstate_t pkg_state_r,
	input logic [`PISR_NCORES-1:0] core_power_up_r,
	input logic wake_fwd_r,
	input logic [`PISR_CIDX_W-1:0] wake_fwd_core_r,
	input logic llc_flush_allow_r,
	input logic sa_power_off_r,
	input logic core_clk_min_r,
	input logic core_volt_low_r
);
	import pisr_pkg::*;
	logic any_c0;
	logic all_c7;
	assign any_c0 = core0_state == 3'h0 || core1_state == 3'h0
		|| core2_state == 3'h0 || core3_state == 3'h0;
	assign all_c7 = &{core0_state, core1_state, core2_state, core3_state};
	logic all_deep;
	assign all_deep = core0_state >= 3'h3 && core1_state >= 3'h3
		&& core2_state >= 3'h3 && core3_state >= 3'h3;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// ****************************************
	// Assertions
	// ****************************************
	a_reset_idle: assert property (disable iff (1'b0) !resetn
		|=> pkg_state_r == PKG_C0) else $error("not idle after reset");
	a_core_active: assert property (any_c0
		|=> pkg_state_r == PKG_C0) else $error("active core not C0");
	a_c7_all: assert property (pkg_state_r == PKG_C7
		|-> $past(all_c7)) else $error("C7 without all cores C7");
	// Permission copy and resolve together lag two edges, so wait for them to settle
	a_allow_cap: assert property ($stable(plat_allow)[*3]
		##0 !plat_hold |-> pkg_state_r <= plat_allow)
		else $error("package deeper than granted");
	a_wake_fwd: assert property (wake_fwd_r |-> pkg_state_r == PKG_C0
		&& $past(wake_valid) && core_power_up_r == (4'h1 << wake_fwd_core_r))
		else $error("bad wake forward");
	a_ramp_order: assert property ($rose(core_volt_low_r)
		|-> core_clk_min_r && $past(core_clk_min_r, 10))
		else $error("voltage dropped before clock settle");
	a_ramp_cause: assert property ($rose(core_clk_min_r)
		|-> $past(pkg_state_r) == PKG_ENHANCED_IDLE)
		else $error("ramp without enhanced idle");
	a_mem_break: assert property (mem_req && !wake_valid && !plat_hold
		&& !$past(plat_hold) && pkg_state_r >= PKG_C3 && all_deep
		&& gfx_deep && !pkg_limit_c1 && $past(plat_allow) >= PKG_C2
		|=> pkg_state_r == PKG_C2) else $error("memory wake not C2");
	a_llc_deep: assert property (llc_flush_allow_r
		|-> pkg_state_r == PKG_C7
		|| (pkg_state_r == PKG_C6 && $past(all_c7)))
		else $error("cache flush in shallow state");
	a_sa_c7: assert property (sa_power_off_r
		== (pkg_state_r == PKG_C7)) else $error("agent off outside C7");
endmodule // pisr_top_sva

bind pisr_top pisr_top_sva u_sva (.clk, .resetn, .core0_state,
	.core1_state, .core2_state, .core3_state, .gfx_deep, .pkg_limit_c1,
	.plat_allow, .plat_hold,
	.mem_req, .wake_valid, .pkg_state_r, .core_power_up_r, .wake_fwd_r,
	.wake_fwd_core_r, .llc_flush_allow_r, .sa_power_off_r,
	.core_clk_min_r, .core_volt_low_r);

// [tb/pisr_plat_model.sv]
/* Platform controller model: grants package depth and hold requests.
 * Assumes the resolver acknowledges each change with plat_ack_r. */
`timescale 1ns/1ps
module pisr_plat_model
(
	input logic clk,
	input logic resetn,
	input logic plat_ack_r,
	input pisr_pkg::pisr_pstate_t want_allow,
	input logic want_hold,
	output pisr_pkg::pisr_pstate_t plat_allow,
	output logic plat_hold
);
	import pisr_pkg::*;
	logic busy_r;
	// Never changes a grant mid-handshake, so late acks stay paired
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			plat_allow <= PKG_C0;
			plat_hold <= 1'b0;
			busy_r <= 1'b0;
		end
		else if (busy_r)
			busy_r <= !plat_ack_r;
		else if (want_allow != plat_allow || want_hold != plat_hold)
		begin
			plat_allow <= want_allow;
			plat_hold <= want_hold;
			busy_r <= 1'b1;
		end
	end
endmodule // pisr_plat_model

// [tb/pisr_top_tb.sv]
/* Self-checking bench for the package idle state resolver.
 * Assumes the platform model and checker are compiled before it. */
`timescale 1ns/1ps
module pisr_top_tb;
	import pisr_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] cs = 12'h000;
	logic [10:0] f = 11'h041;
	pisr_pstate_t want_allow = PKG_C0;
	logic want_hold = 1'b0;
	pisr_pstate_t plat_allow;
	logic plat_hold;
	pisr_pstate_t plat_hold_state = PKG_C1;
	logic mem_req = 1'b0;
	logic mem_outstanding = 1'b0;
	logic wake_valid = 1'b0;
	logic [1:0] wake_core = 2'h2;
	logic wake_masked = 1'b0;
	pisr_pstate_t pkg_state_r;
	logic [3:0] core_power_up_r;
	logic wake_fwd_r;
	logic [1:0] wake_fwd_core_r;
	logic plat_ack_r;
	logic llc_flush_allow_r;
	logic sa_power_off_r;
	logic core_clk_min_r;
	logic core_volt_low_r;
	int fails = 0;
	int n_tests = 0;

	pisr_top dut (.clk, .resetn, .core0_state(cs[2:0]),
		.core1_state(cs[5:3]), .core2_state(cs[8:6]),
		.core3_state(cs[11:9]), .core_enhanced_idle_hint(f[10:7]),
		.gfx_deep(f[0]), .enh_idle_enable(f[1]),
		.auto_promote_enable(f[2]), .pkg_limit_c1(f[3]),
		.latency_limit_c2(f[4]), .discrete_gfx(f[5]),
		.c7_efficient(f[6]), .plat_allow, .plat_hold, .plat_hold_state,
		.mem_req, .mem_outstanding, .wake_valid, .wake_core, .wake_masked,
		.pkg_state_r, .core_power_up_r, .wake_fwd_r, .wake_fwd_core_r,
		.plat_ack_r, .llc_flush_allow_r, .sa_power_off_r, .core_clk_min_r,
		.core_volt_low_r);
	pisr_plat_model plat (.clk, .resetn, .plat_ack_r, .want_allow,
		.want_hold, .plat_allow, .plat_hold);

	initial
	begin
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic chk_pkg(input pisr_pstate_t e);
		check({1'b0, pkg_state_r}, {1'b0, e});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Eight edges cover partner, permission copy and resolve lag
	task automatic row(input logic [11:0] c, input pisr_pstate_t a,
		input logic [10:0] fl, input pisr_pstate_t e);
		@(posedge clk);
		cs <= c;
		want_allow <= a;
		f <= fl;
		tick(8);
		chk_pkg(e);
	endtask

	task automatic wake(input logic m, input logic [1:0] c);
		int k;
		@(posedge clk);
		wake_valid <= 1'b1;
		wake_masked <= m;
		wake_core <= c;
		@(posedge clk);
		wake_valid <= 1'b0;
		k = 0;
		#1;
		while (wake_fwd_r !== 1'b1 && k < 3)
		begin
			tick(1);
			k++;
		end
		check({3'b0, wake_fwd_r}, 4'h1);
		check({2'b0, wake_fwd_core_r}, {2'b0, c});
		check(core_power_up_r, 4'h1 << c);
		chk_pkg(PKG_C0);
	endtask

	task automatic mem(input logic out);
		@(posedge clk);
		mem_req <= 1'b1;
		mem_outstanding <= out;
		@(posedge clk);
		mem_req <= 1'b0;
		tick(2);
	endtask

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge clk);
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		summarize;
	end

	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		tick(1);
		chk_pkg(PKG_C0);
		row(12'hfff, PKG_C7, 11'h041, PKG_C7);
		check({3'b0, sa_power_off_r}, 4'h1);
		row(12'hfff, PKG_C7, 11'h061, PKG_C6);
		check({3'b0, llc_flush_allow_r}, 4'h1);
		row(12'hfff, PKG_C7, 11'h001, PKG_C6);
		row(12'hff7, PKG_C7, 11'h041, PKG_C6);
		check({3'b0, llc_flush_allow_r}, 4'h0);
		row(12'hff3, PKG_C7, 11'h041, PKG_C3);
		row(12'hfff, PKG_C3, 11'h041, PKG_C3);
		row(12'hfff, PKG_C0, 11'h041, PKG_C0);
		row(12'hfff, PKG_C7, 11'h051, PKG_C2);
		row(12'hff8, PKG_C7, 11'h041, PKG_C0);
		row(12'hff9, PKG_C7, 11'h043, PKG_C1);
		row(12'hff9, PKG_C7, 11'h7c3, PKG_ENHANCED_IDLE);
		tick(12);
		check({2'b0, core_clk_min_r, core_volt_low_r}, 4'h3);
		row(12'hff9, PKG_C7, 11'h047, PKG_ENHANCED_IDLE);
		row(12'hfff, PKG_C7, 11'h04b, PKG_ENHANCED_IDLE);
		row(12'hff9, PKG_C7, 11'h041, PKG_C1);
		tick(16);
		check({2'b0, core_clk_min_r, core_volt_low_r}, 4'h0);
		$display("test resolution done");
		row(12'hfff, PKG_C6, 11'h041, PKG_C6);
		wake(1'b1, 2'h1);
		tick(1);
		chk_pkg(PKG_C6);
		wake(1'b0, 2'h2);
		row(12'he3f, PKG_C6, 11'h041, PKG_C0);
		row(12'hfff, PKG_C3, 11'h041, PKG_C3);
		$display("test wake done");
		mem(1'b1);
		chk_pkg(PKG_C2);
		@(posedge clk);
		mem_outstanding <= 1'b0;
		tick(3);
		chk_pkg(PKG_C3);
		@(posedge clk);
		want_hold <= 1'b1;
		tick(2);
		check({3'b0, plat_ack_r}, 4'h1);
		tick(2);
		mem(1'b0);
		chk_pkg(PKG_C1);
		@(posedge clk);
		want_hold <= 1'b0;
		tick(6);
		chk_pkg(PKG_C3);
		$display("test memory done");
		summarize;
	end
endmodule // pisr_top_tb
